// >>> shared/nv_mux_pkg.sv
// Constants and types for the non-volatile output multiplexer
package nv_mux_pkg;
    localparam int DATA_W = 6;
    localparam int SLOT_COUNT = 4;
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4C;
    localparam logic [DATA_W-1:0] SLOT_RESET = 6'h00;
    localparam logic [7:0] CMD_SLOT_LAST = 8'h03;
    localparam logic [7:0] CMD_MUX_PIN = 8'hF0;
    localparam logic [7:0] CMD_MUX_HW = 8'hF2;
    localparam logic [5:0] CMD_MUX_SLOT_TOP = 6'h3E;
    localparam logic [7:0] CMD_READ_HW = 8'hFF;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {
        MODE_PIN  = 3'b001,
        MODE_HW   = 3'b010,
        MODE_SLOT = 3'b100
    } mux_mode_e;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_AACK = 7'b000_0100,
        ST_RX   = 7'b000_1000,
        ST_WACK = 7'b001_0000,
        ST_TX   = 7'b010_0000,
        ST_MACK = 7'b100_0000
    } bus_state_e;
endpackage

// >>> rtl/nv_output_mux.sv
// Serial-bus slave with four non-volatile slots driving a six-bit output multiplexer
//
// Contract
// - Answer slave address 1001100; strap level sets the address LSB.
// - Four independent six-bit slots 0..3, writable and readable over the bus.
// - Slot programming accepted only while write-protect permits it.
// - Source select pin chooses slot value or hardware select inputs.
// - Bus write sets mux configuration: pin control, hardware inputs or slot 0..3.
// - All four slots written in one transaction and read in one.
// - Master can read back current hardware select input levels.
// - Six hardware select inputs, one per output bit.
// - Write-protect tied low permits slot programming.
// - Source select pin high (floating) selects the hardware inputs.
// - After power-up outputs follow hardware inputs until reconfigured.
module nv_output_mux
    import nv_mux_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_strap_i,
    input wire logic write_protect_i,
    input wire logic mux_select_i,
    input wire logic [DATA_W-1:0] hw_sel_i,
    output logic [DATA_W-1:0] mux_out_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////
    bus_state_e state_reg, state_next;
    logic scl_prev_reg, sda_prev_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic first_reg, first_next;
    logic nack_reg, nack_next;
    logic oe_reg, oe_next;
    logic [SLOT_COUNT-1:0][DATA_W-1:0] slot_reg, slot_next;
    mux_mode_e mode_reg, mode_next;
    logic [1:0] sel_reg, sel_next;
    logic [DATA_W-1:0] out_reg, out_next;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [6:0] own_addr;
    logic [7:0] tx_byte;

    assign scl_rise = scl_i && !scl_prev_reg;
    assign scl_fall = !scl_i && scl_prev_reg;
    assign start_seen = scl_i && scl_prev_reg && sda_prev_reg && !sda_i;
    assign stop_seen = scl_i && scl_prev_reg && !sda_prev_reg && sda_i;
    assign own_addr = {SLAVE_ADDR_BASE[6:1], address_strap_i};

    always_comb begin
        if (ptr_reg == CMD_READ_HW) begin
            tx_byte = {2'b00, hw_sel_i};
        end else if (ptr_reg <= CMD_SLOT_LAST) begin
            tx_byte = {2'b00, slot_reg[ptr_reg[1:0]]};
        end else begin
            tx_byte = 8'h00;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        nack_next = nack_reg;
        oe_next = oe_reg;
        slot_next = slot_reg;
        mode_next = mode_reg;
        sel_next = sel_reg;
        if (start_seen) begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_seen) begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    oe_next = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_i};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                        if (state_reg == ST_RX) begin
                            state_next = ST_WACK;
                            oe_next = 1'b1;
                            first_next = 1'b0;
                            if (first_reg) begin
                                ptr_next = shift_reg;
                                if (shift_reg == CMD_MUX_PIN) begin
                                    mode_next = MODE_PIN;
                                end else if (shift_reg == CMD_MUX_HW) begin
                                    mode_next = MODE_HW;
                                end else if (shift_reg[7:2] == CMD_MUX_SLOT_TOP) begin
                                    mode_next = MODE_SLOT;
                                    sel_next = shift_reg[1:0];
                                end
                            end else if (ptr_reg <= CMD_SLOT_LAST) begin
                                if (!write_protect_i) begin
                                    slot_next[ptr_reg[1:0]] = shift_reg[DATA_W-1:0];
                                end
                                ptr_next = {6'h00, ptr_reg[1:0] + 2'b01};
                            end
                        end else if (shift_reg[7:1] == own_addr) begin
                            state_next = ST_AACK;
                            oe_next = 1'b1;
                            rw_next = shift_reg[0];
                            first_next = 1'b1;
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_WACK, ST_MACK: begin
                    if (state_reg == ST_MACK && scl_rise) begin
                        nack_next = sda_i;
                    end else if (scl_fall) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b0;
                        if (state_reg == ST_MACK && nack_reg) begin
                            state_next = ST_IDLE;
                        end else if (state_reg != ST_WACK && (state_reg == ST_MACK || rw_reg)) begin
                            state_next = ST_TX;
                            shift_next = tx_byte;
                            oe_next = !tx_byte[7];
                            if (ptr_reg <= CMD_SLOT_LAST) begin
                                ptr_next = {6'h00, ptr_reg[1:0] + 2'b01};
                            end
                        end else begin
                            state_next = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        cnt_next = cnt_reg + 4'h1;
                        shift_next = {shift_reg[6:0], 1'b0};
                        if (cnt_reg == TX_LAST_BIT) begin
                            state_next = ST_MACK;
                            oe_next = 1'b0;
                        end else begin
                            oe_next = !shift_reg[6];
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        unique case (mode_reg)
            MODE_HW: out_next = hw_sel_i;
            MODE_SLOT: out_next = slot_reg[sel_reg];
            // pin chooses source; high selects hardware
            MODE_PIN: out_next = mux_select_i ? hw_sel_i : slot_reg[sel_reg];
            default: out_next = hw_sel_i;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= PTR_RESET;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
            slot_reg <= {SLOT_COUNT{SLOT_RESET}};
            mode_reg <= MODE_HW;
            sel_reg <= 2'b00;
            out_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            scl_prev_reg <= scl_i;
            sda_prev_reg <= sda_i;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            nack_reg <= nack_next;
            oe_reg <= oe_next;
            slot_reg <= slot_next;
            mode_reg <= mode_next;
            sel_reg <= sel_next;
            out_reg <= out_next;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;
    assign mux_out_o = out_reg;

    ////////////////////////////////////////////////////////////////////////
    addr_ack_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_reg == ST_ADDR && state_next == ST_AACK) |-> shift_reg[7:1] == own_addr)
        else $error("address acknowledged with wrong address");
    protect_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        write_protect_i |=> slot_reg == $past(slot_reg))
        else $error("slot changed while write protected");
    slot_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_reg == ST_RX && state_next == ST_WACK && !first_reg && ptr_reg <= CMD_SLOT_LAST
         && !write_protect_i) |=> slot_reg[$past(ptr_reg[1:0])] == $past(shift_reg[DATA_W-1:0]))
        else $error("permitted slot write not stored");
    pin_hw_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mode_reg == MODE_PIN && mux_select_i) |=> mux_out_o == $past(hw_sel_i))
        else $error("pin high did not select hardware inputs");
    pin_slot_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mode_reg == MODE_PIN && !mux_select_i) |=> mux_out_o == $past(slot_reg[sel_reg]))
        else $error("pin low did not select slot");
    slot_cmd_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_reg == ST_RX && state_next == ST_WACK && first_reg && shift_reg[7:2] == CMD_MUX_SLOT_TOP)
        |=> mode_reg == MODE_SLOT && sel_reg == $past(shift_reg[1:0]))
        else $error("slot mux command not applied");
    hw_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        mode_reg == MODE_HW |=> mux_out_o == $past(hw_sel_i))
        else $error("outputs not following hardware inputs");
    hw_readback_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_reg != ST_TX && state_next == ST_TX && ptr_reg == CMD_READ_HW)
        |=> shift_reg == {2'b00, $past(hw_sel_i)} && oe_reg == 1'b1)
        else $error("hardware readback byte wrong");
    ptr_advance_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (state_reg == ST_RX && state_next == ST_WACK && !first_reg && ptr_reg <= CMD_SLOT_LAST)
        |=> ptr_reg == {6'h00, $past(ptr_reg[1:0]) + 2'b01})
        else $error("slot pointer did not advance");
endmodule

// >>> verification/bus_master_model.sv
// Serial bus master model: drives the clock and pulls the data wire low
module bus_master_model (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Eight cycles per phase, eight times the one-cycle minimum the slave needs
    task automatic half();
        repeat (8) @(negedge mclk_i);
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        sda_low_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b0;
        half();
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_low_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        s = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, s);
    endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the slot-backed output multiplexer
module tb;
    import nv_mux_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic strap = 1'b0;
    logic wp = 1'b0;
    logic msel = 1'b1;
    logic [DATA_W-1:0] hw = 6'h00;
    logic [DATA_W-1:0] mux_out;
    logic sda_o, sda_oe, scl, m_low, sda;
    logic [7:0] seen;
    logic [7:0] lfsr = 8'h1E;
    logic [7:0] exp_q[$];
    logic [5:0] slot_v[4] = '{6'h2A, 6'h15, 6'h0E, 6'h31};
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    event got;
    always #25 mclk_i = ~mclk_i;
    // Pull-up wins unless someone pulls low
    assign sda = ~(m_low | (sda_oe & ~sda_o));
    nv_output_mux uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .address_strap_i(strap), .write_protect_i(wp), .mux_select_i(msel),
        .hw_sel_i(hw), .mux_out_o(mux_out));
    bus_master_model m (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic check(input logic [7:0] v, input logic [7:0] e);
        check_count++;
        if (v !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d of %0d compares", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic result(input logic [7:0] v, input logic [7:0] e);
        exp_q.push_back(e);
        seen = v;
        ->got;
        #1;
    endtask
    always @(got) check(seen, exp_q.pop_front());
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] b, input logic ack_exp);
        logic a;
        m.wbyte(b, a);
        result({7'h00, a}, {7'h00, ack_exp});
    endtask
    task automatic rd(input logic [7:0] e, input logic last);
        logic [7:0] v;
        m.rbyte(last, v);
        result(v, e);
    endtask
    task automatic out_is(input logic [5:0] e);
        repeat (3) @(negedge mclk_i);
        result({2'b00, mux_out}, {2'b00, e});
    endtask
    task automatic open(input logic [7:0] c);
        m.start();
        xfer({SLAVE_ADDR_BASE, 1'b0}, 1'b1);
        xfer(c, 1'b1);
    endtask
    task automatic prog(input logic use_rnd);
        open(PTR_RESET);
        for (int i = 0; i < SLOT_COUNT; i++) xfer(use_rnd ? rnd() : {2'b11, slot_v[i]}, 1'b1);
        m.stop();
    endtask
    task automatic read_slots();
        open(PTR_RESET);
        m.start();
        xfer({SLAVE_ADDR_BASE, 1'b1}, 1'b1);
        for (int i = 0; i < SLOT_COUNT; i++) rd({2'b00, slot_v[i]}, i == SLOT_COUNT - 1);
        m.stop();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        hw = 6'(rnd());
        out_is(hw);
        prog(1'b0);
        read_slots();
        for (int i = 0; i < SLOT_COUNT; i++) begin
            open(8'hF8 + 8'(i));
            m.stop();
            out_is(slot_v[i]);
        end
        wp = 1'b1;
        prog(1'b1);
        read_slots();
        open(CMD_MUX_HW);
        m.stop();
        for (int i = 0; i < 4; i++) begin
            hw = 6'(rnd());
            out_is(hw);
        end
        open(CMD_READ_HW);
        m.start();
        xfer({SLAVE_ADDR_BASE, 1'b1}, 1'b1);
        rd({2'b00, hw}, 1'b1);
        m.stop();
        open(8'hFA);
        m.stop();
        open(CMD_MUX_PIN);
        m.stop();
        out_is(hw);
        msel = 1'b0;
        out_is(slot_v[2]);
        hw = ~hw;
        msel = 1'b1;
        out_is(hw);
        strap = 1'b1;
        m.start();
        xfer({SLAVE_ADDR_BASE, 1'b0}, 1'b0);
        m.stop();
        m.start();
        xfer({SLAVE_ADDR_BASE[6:1], 2'b10}, 1'b1);
        xfer(8'hFB, 1'b1);
        m.stop();
        out_is(slot_v[3]);
        complete_run();
    end
endmodule
